// >>> design/serial_flash_cmd.sv
// command front end of a serial flash: latch, status and read commands
//
// Summary of operation
// - write enable opcode sets the latch
// - write disable opcode clears the latch
// - latch clears at reset and op end
// - volatile enable makes next write volatile
// - status read shifts selected byte out
// - status reads accepted even while busy
// - status byte repeats until deselect
// - full write changes only three bits
// - write runs only after 8/16 bits
// - eight-bit write zeroes three bits
// - timed cycle holds busy, clears latch
// - second write takes one byte
// - read data: address then byte out
// - address increments, stream continues
// - read data ignored while busy
// - fast read eight dummy clocks
// - four-wire dummy count from parameters
// - four-wire dummy count defaults four
// - nibbles lane three holds msb
// - quad data high nibble first
// - everything shifts msb first
`timescale 1ns/1ps
`include "serial_flash_params.svh"

module serial_flash_cmd #(
  parameter int WRITE_CYCLES = `STATUS_WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut_q,
  output logic [3:0] ioOe_q,
  input wire logic fourWireMode,
  input wire logic swReset,
  input wire logic arrayBusy,
  input wire logic arrayOpDone,
  output logic [23:0] memAddr_q,
  input wire logic [7:0] memRdData,
  output serial_flash_pkg::status_t status_q
);

  // ----------------------------------------
  // pin synchronisers and edge finding
  // ----------------------------------------
  logic [2:0] sclkSync_q;
  logic [2:0] csSync_q;
  logic [3:0] ioS1_q;
  logic [3:0] ioS2_q;
  logic sclkRise;
  logic sclkFall;
  logic csActive;
  logic csRise;

  // two flops per pin, a third for edge detection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclkSync_q <= 3'h0;
      csSync_q <= 3'h7;
      ioS1_q <= 4'h0;
      ioS2_q <= 4'h0;
    end
    else
    begin
      sclkSync_q <= {sclkSync_q[1:0], sclk};
      csSync_q <= {csSync_q[1:0], csN};
      ioS1_q <= ioIn;
      ioS2_q <= ioS1_q;
    end
  end

  assign sclkRise = sclkSync_q[1] & ~sclkSync_q[2] & ~csSync_q[1];
  assign sclkFall = ~sclkSync_q[1] & sclkSync_q[2] & ~csSync_q[1];
  assign csActive = ~csSync_q[1];
  assign csRise = csSync_q[1] & ~csSync_q[2];

  // ----------------------------------------
  // serial input assembly
  // ----------------------------------------
  serial_flash_pkg::dec_state_t state_q;
  logic [7:0] shift_q;
  logic [3:0] bitCnt_q;
  logic [3:0] bitCnt_d;
  logic [7:0] rxByte;
  logic byteDone;
  logic [7:0] cmd_q;
  logic [1:0] byteCnt_q;
  logic [23:0] addr_q;
  logic [3:0] dummyCnt_q;
  logic [3:0] dummyLen_q;
  logic [7:0] data0_q;
  logic [7:0] data1_q;
  logic [2:0] outCnt_q;
  logic [7:0] outShift_q;
  logic loadEv;
  logic busyNow;
  logic volArmed_q;

  // one bit per edge on the data-in lane, or a nibble with msb on lane three
  always_comb
  begin
    if (fourWireMode)
    begin
      rxByte = {shift_q[3:0], ioS2_q};
      bitCnt_d = bitCnt_q + 4'h4;
    end
    else
    begin
      rxByte = {shift_q[6:0], ioS2_q[0]};
      bitCnt_d = bitCnt_q + 4'h1;
    end
  end

  assign byteDone = sclkRise && bitCnt_d[3];
  assign busyNow = status_q.busy | arrayBusy;
  assign loadEv = sclkFall && outCnt_q == 3'h0 && state_q == serial_flash_pkg::ST_OUT_DATA;

  // shift register and bit count, only the count cleared while deselected
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_q <= 8'h00;
      bitCnt_q <= 4'h0;
    end
    else if (!csActive)
    begin
      bitCnt_q <= 4'h0;
    end
    else if (sclkRise)
    begin
      shift_q <= rxByte;
      bitCnt_q <= {1'b0, bitCnt_d[2:0]};
    end
  end

  // ----------------------------------------
  // command decoder
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= serial_flash_pkg::ST_CMD;
      cmd_q <= 8'h00;
      byteCnt_q <= 2'h0;
      addr_q <= 24'h000000;
      dummyCnt_q <= 4'h0;
      data0_q <= 8'h00;
      data1_q <= 8'h00;
    end
    else if (!csActive)
    begin
      state_q <= serial_flash_pkg::ST_CMD;
      byteCnt_q <= 2'h0;
      dummyCnt_q <= 4'h0;
    end
    else
    begin
      unique case (state_q)
        serial_flash_pkg::ST_CMD:
        begin
          if (byteDone)
          begin
            cmd_q <= rxByte;
            unique case (rxByte)
              `OP_READ_STATUS1, `OP_READ_STATUS2:
                state_q <= serial_flash_pkg::ST_OUT_STATUS;
              `OP_WRITE_STATUS, `OP_WRITE_STATUS2:
                if (!busyNow && (status_q.write_enable_latch || volArmed_q))
                  state_q <= serial_flash_pkg::ST_DATA_IN;
                else
                  state_q <= serial_flash_pkg::ST_IGNORE;
              `OP_READ_DATA, `OP_FAST_READ:
                if (busyNow)
                  state_q <= serial_flash_pkg::ST_IGNORE;
                else
                  state_q <= serial_flash_pkg::ST_ADDR;
              `OP_SET_READ_PARAM:
                if (fourWireMode)
                  state_q <= serial_flash_pkg::ST_DATA_IN;
                else
                  state_q <= serial_flash_pkg::ST_IGNORE;
              default:
                state_q <= serial_flash_pkg::ST_IGNORE;
            endcase
          end
        end
        serial_flash_pkg::ST_ADDR:
        begin
          if (byteDone)
          begin
            addr_q <= {addr_q[15:0], rxByte};
            byteCnt_q <= byteCnt_q + 2'h1;
            if (byteCnt_q + 2'h1 == `ADDR_BYTES)
            begin
              if (cmd_q == `OP_FAST_READ)
                state_q <= serial_flash_pkg::ST_DUMMY;
              else
                state_q <= serial_flash_pkg::ST_OUT_DATA;
            end
          end
        end
        serial_flash_pkg::ST_DUMMY:
        begin
          if (sclkRise)
          begin
            dummyCnt_q <= dummyCnt_q + 4'h1;
            if (dummyCnt_q + 4'h1 == (fourWireMode ? dummyLen_q : `DUMMY_SPI))
              state_q <= serial_flash_pkg::ST_OUT_DATA;
          end
        end
        serial_flash_pkg::ST_DATA_IN:
        begin
          if (byteDone)
          begin
            if (byteCnt_q == 2'h0)
              data0_q <= rxByte;
            if (byteCnt_q == 2'h1)
              data1_q <= rxByte;
            if (byteCnt_q != 2'h3)
              byteCnt_q <= byteCnt_q + 2'h1; // saturates so a third byte spoils it
          end
        end
        serial_flash_pkg::ST_OUT_STATUS, serial_flash_pkg::ST_OUT_DATA,
        serial_flash_pkg::ST_IGNORE:
        begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // read address: reloaded after every address byte, bumped per byte sent
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      memAddr_q <= 24'h000000;
    else if (state_q == serial_flash_pkg::ST_ADDR && byteDone)
      memAddr_q <= {addr_q[15:0], rxByte};
    else if (loadEv)
      memAddr_q <= memAddr_q + 24'h000001;
  end

  // ----------------------------------------
  // serial output on falling edges
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      outCnt_q <= 3'h0;
      outShift_q <= 8'h00;
      ioOut_q <= 4'h0;
      ioOe_q <= 4'h0;
    end
    else if (!csActive || (state_q != serial_flash_pkg::ST_OUT_STATUS
                           && state_q != serial_flash_pkg::ST_OUT_DATA))
    begin
      outCnt_q <= 3'h0;
      ioOe_q <= 4'h0;
    end
    else if (sclkFall)
    begin
      logic [7:0] src;
      src = outShift_q;
      if (outCnt_q == 3'h0)
      begin
        if (state_q == serial_flash_pkg::ST_OUT_DATA)
          src = memRdData;
        else if (cmd_q == `OP_READ_STATUS2)
          src = status_q[15:8];
        else
          src = status_q[7:0];
      end
      if (fourWireMode)
      begin
        ioOut_q <= src[7:4];
        ioOe_q <= 4'hf;
        outShift_q <= {src[3:0], 4'h0};
        outCnt_q <= outCnt_q + 3'h4;
      end
      else
      begin
        ioOut_q <= {2'b00, src[7], 1'b0};
        ioOe_q <= 4'h2;
        outShift_q <= {src[6:0], 1'b0};
        outCnt_q <= outCnt_q + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // status write execution
  // ----------------------------------------
  logic writeGo;
  logic paramGo;
  logic [3:0] pendBits_q;
  logic [3:0] newBits;
  logic [15:0] timer_q;
  logic timerDone;

  // valid only with exactly one or two data bytes at deselect
  always_comb
  begin
    writeGo = 1'b0;
    newBits = {status_q.protect_complement, status_q.quad_lane_enable,
               status_q.protect_lock_bit_one, status_q.protect_lock_bit_zero};
    if (csRise && state_q == serial_flash_pkg::ST_DATA_IN && bitCnt_q == 4'h0)
    begin
      if (cmd_q == `OP_WRITE_STATUS2 && byteCnt_q == 2'h1)
      begin
        writeGo = 1'b1;
        newBits[3:1] = {data0_q[`SR2_COMPL_BIT], data0_q[`SR2_QUAD_BIT],
                        data0_q[`SR2_LOCK1_BIT]};
      end
      else if (cmd_q == `OP_WRITE_STATUS && byteCnt_q == 2'h1)
      begin
        writeGo = 1'b1;
        newBits = {3'b000, data0_q[`SR1_LOCK0_BIT]};
      end
      else if (cmd_q == `OP_WRITE_STATUS && byteCnt_q == 2'h2)
      begin
        writeGo = 1'b1;
        newBits[2:0] = {data1_q[`SR2_QUAD_BIT], data1_q[`SR2_LOCK1_BIT],
                        data0_q[`SR1_LOCK0_BIT]};
      end
    end
  end

  assign paramGo = csRise && state_q == serial_flash_pkg::ST_DATA_IN && bitCnt_q == 4'h0
                   && cmd_q == `OP_SET_READ_PARAM && byteCnt_q == 2'h1;
  assign timerDone = status_q.busy && timer_q == 16'h0000;

  // self-timed write cycle counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_q <= 16'h0000;
      pendBits_q <= 4'h0;
    end
    else if (writeGo && !volArmed_q)
    begin
      timer_q <= 16'(WRITE_CYCLES - 1);
      pendBits_q <= newBits;
    end
    else if (timer_q != 16'h0000)
    begin
      timer_q <= timer_q - 16'h0001;
    end
  end

  // read parameter dummy count, four after reset or software reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dummyLen_q <= `DUMMY_QPI_DEFAULT;
    else if (swReset)
      dummyLen_q <= `DUMMY_QPI_DEFAULT;
    else if (paramGo)
    begin
      unique case (data0_q[`PARAM_DUMMY_HI:`PARAM_DUMMY_LO])
        2'b00: dummyLen_q <= `DUMMY_QPI_DEFAULT;
        2'b01: dummyLen_q <= `DUMMY_QPI_SIX;
        2'b10, 2'b11: dummyLen_q <= `DUMMY_QPI_EIGHT;
      endcase
    end
  end

  // volatile write arming, spent by the next status write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      volArmed_q <= 1'b0;
    else if (sclkRise && byteDone && state_q == serial_flash_pkg::ST_CMD
             && rxByte == `OP_VOLATILE_ENABLE)
      volArmed_q <= 1'b1;
    else if (writeGo)
      volArmed_q <= 1'b0;
  end

  // ----------------------------------------
  // status register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status_q <= `STATUS_RESET;
    else
    begin
      if (writeGo && volArmed_q)
        {status_q.protect_complement, status_q.quad_lane_enable,
         status_q.protect_lock_bit_one, status_q.protect_lock_bit_zero} <= newBits;
      if (writeGo && !volArmed_q)
      begin
        status_q.busy <= 1'b1;
        status_q.write_enable_latch <= 1'b0;
      end
      if (timerDone)
      begin
        status_q.busy <= 1'b0;
        {status_q.protect_complement, status_q.quad_lane_enable,
         status_q.protect_lock_bit_one, status_q.protect_lock_bit_zero} <= pendBits_q;
      end
      if (arrayOpDone)
        status_q.write_enable_latch <= 1'b0;
      if (byteDone && state_q == serial_flash_pkg::ST_CMD)
      begin
        if (rxByte == `OP_WRITE_DISABLE)
          status_q.write_enable_latch <= 1'b0;
        if (rxByte == `OP_WRITE_ENABLE)
          status_q.write_enable_latch <= 1'b1;
      end
    end
  end

endmodule

// >>> design/serial_flash_params.svh
// constants for the serial flash command front end
`ifndef SERIAL_FLASH_PARAMS_SVH
`define SERIAL_FLASH_PARAMS_SVH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_VOLATILE_ENABLE 8'h50
`define OP_READ_STATUS1 8'h05
`define OP_READ_STATUS2 8'h35
`define OP_WRITE_STATUS 8'h01
`define OP_WRITE_STATUS2 8'h31
`define OP_READ_DATA 8'h03
`define OP_FAST_READ 8'h0b
`define OP_SET_READ_PARAM 8'hc0
// ----------------------------------------
// data byte field positions
// ----------------------------------------
`define SR1_LOCK0_BIT 7
`define SR2_LOCK1_BIT 0
`define SR2_QUAD_BIT 1
`define SR2_COMPL_BIT 6
`define PARAM_DUMMY_LO 4
`define PARAM_DUMMY_HI 5
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define STATUS_RESET 16'h0000
`define ADDR_BYTES 2'h3
`define DUMMY_SPI 4'h8
`define DUMMY_QPI_DEFAULT 4'h4
`define DUMMY_QPI_SIX 4'h6
`define DUMMY_QPI_EIGHT 4'h8
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define STATUS_WRITE_US 15
`define STATUS_WRITE_CYCLES (`STATUS_WRITE_US * 1000 / `CLK_PERIOD_NS)
`endif

// >>> design/serial_flash_pkg.sv
// types for the serial flash command front end
package serial_flash_pkg;
  // ----------------------------------------
  // command decoder states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA_IN, ST_OUT_STATUS, ST_OUT_DATA, ST_IGNORE
  } dec_state_t;
  // ----------------------------------------
  // the two status bytes, bit 15 down to bit 0
  // ----------------------------------------
  typedef struct packed {
    logic suspended_flag;
    logic protect_complement;
    logic [3:0] reserved;
    logic quad_lane_enable;
    logic protect_lock_bit_one;
    logic protect_lock_bit_zero;
    logic [4:0] protect;
    logic write_enable_latch;
    logic busy;
  } status_t;
endpackage

// >>> sim/serial_flash_cmd_assertions.sv
// port checker for the serial flash command front end
`timescale 1ns/1ps
module serial_flash_cmd_checker #(
  parameter int WRITE_CYCLES = 750
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic [3:0] ioOut_q,
  input wire logic [3:0] ioOe_q,
  input wire logic fourWireMode,
  input wire logic arrayOpDone,
  input wire serial_flash_pkg::status_t status_q
);
  localparam int BUSY_LO = WRITE_CYCLES - 2;
  localparam int BUSY_HI = WRITE_CYCLES + 2;
  logic [15:0] busyCnt_q;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // helper: length of the running timed write
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      busyCnt_q <= 16'h0000;
    else if (status_q.busy)
      busyCnt_q <= busyCnt_q + 16'h0001;
    else
      busyCnt_q <= 16'h0000;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_oe_idle: assert property (csN [*6] |-> ioOe_q == 4'h0)
    else $error("lanes driven while deselected");
  a_oe_single: assert property (!fourWireMode |-> ioOe_q inside {4'h0, 4'h2})
    else $error("wrong lane enabled in single-wire mode");
  a_oe_quad: assert property (fourWireMode |-> ioOe_q inside {4'h0, 4'hf})
    else $error("partial lane set enabled in four-wire mode");
  a_out_on_fall: assert property (ioOe_q[1] && $past(ioOe_q[1]) && $changed(ioOut_q[1])
    |-> !$past(sclk, 2))
    else $error("output bit moved without a falling link clock");
  a_busy_latch: assert property ($rose(status_q.busy)
    |-> ##[0:1] !status_q.write_enable_latch)
    else $error("latch still set once busy");
  a_busy_length: assert property ($fell(status_q.busy)
    |-> busyCnt_q >= BUSY_LO && busyCnt_q <= BUSY_HI)
    else $error("timed write has wrong length");
  a_bits_deselect: assert property ($changed({status_q.protect_complement,
    status_q.quad_lane_enable, status_q.protect_lock_bit_one, status_q.protect_lock_bit_zero})
    |-> csN && !status_q.busy)
    else $error("writable bits changed mid frame or mid cycle");
  a_fixed_zero: assert property (status_q.protect == 5'h00 && status_q.reserved == 4'h0
    && !status_q.suspended_flag)
    else $error("read-only status bits changed");
  a_done_clears: assert property (csN [*8] ##0 arrayOpDone
    |=> !status_q.write_enable_latch)
    else $error("latch survived end of array operation");
endmodule

bind serial_flash_cmd serial_flash_cmd_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_checker (
  .clk(clk),
  .rst_n(rst_n),
  .sclk(sclk),
  .csN(csN),
  .ioOut_q(ioOut_q),
  .ioOe_q(ioOe_q),
  .fourWireMode(fourWireMode),
  .arrayOpDone(arrayOpDone),
  .status_q(status_q)
);

// >>> sim/serial_flash_cmd_tb.sv
// self-checking bench for the serial flash command front end
`timescale 1ns/1ps
module serial_flash_cmd_tb;
  localparam int W = 400;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic arrayBusy = 1'b0;
  logic arrayOpDone = 1'b0;
  logic swReset = 1'b0;
  logic fourWire = 1'b0;
  logic [7:0] memRdData = 8'h00;
  logic sclk;
  logic csN;
  logic [3:0] ioIn;
  logic [3:0] ioOut_q;
  logic [3:0] ioOe_q;
  logic [23:0] memAddr_q;
  serial_flash_pkg::status_t status_q;
  logic [63:0] rx;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  wire logic [3:0] lanes = ~(ioOut_q ^ ioOe_q); // floating lanes show the inverse of the last level

  serial_flash_cmd #(.WRITE_CYCLES(W)) u_serial_flash_cmd (.clk(clk), .rst_n(rst_n),
    .sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut_q(ioOut_q), .ioOe_q(ioOe_q),
    .fourWireMode(fourWire), .swReset(swReset), .arrayBusy(arrayBusy),
    .arrayOpDone(arrayOpDone), .memAddr_q(memAddr_q), .memRdData(memRdData),
    .status_q(status_q));
  serial_flash_host u_serial_flash_host (.sclk(sclk), .csN(csN), .ioIn(ioIn), .lanes(lanes));

  always #10 clk = ~clk;
  // array stand-in mixes the two low address bytes
  always @(posedge clk)
    memRdData <= memAddr_q[7:0] ^ memAddr_q[15:8];
  // cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      finish_test();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  function automatic logic [23:0] st();
    return {8'h00, status_q};
  endfunction
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic [63:0] tx, input int n);
    @(posedge clk);
    u_serial_flash_host.frame(tx, n, fourWire, rx);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 1000 && status_q.busy !== 1'b0; i++)
      @(posedge clk);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    check("status after reset", 24'h000000, st());
    xfer(64'h0, 4);
    check("latch after partial", 24'h000000, st());
    xfer(64'h06, 8);
    check("latch set", 24'h000002, st());
    xfer(64'h050000, 24);
    check("status 1 read", 24'h000202, {8'h00, rx[15:0]});
    xfer(64'h04, 8);
    check("latch cleared", 24'h000000, st());
    $display("test latch finished");
    xfer(64'h01ffff, 24);
    repeat (W + 20) @(posedge clk);
    check("unarmed write", 24'h000000, st());
    xfer(64'h06, 8);
    xfer(64'h01ffff, 24);
    check("write cycle start", 24'h000001, st());
    xfer(64'h050000, 24);
    check("read while busy", 24'h000101, {8'h00, rx[15:0]});
    wait_idle();
    check("full write", 24'h000380, st());
    xfer(64'h350000, 24);
    check("status 2 read", 24'h000303, {8'h00, rx[15:0]});
    xfer(64'h06, 8);
    xfer(64'h3140, 16);
    wait_idle();
    check("second write", 24'h004080, st());
    xfer(64'h06, 8);
    xfer(64'h0100, 16);
    wait_idle();
    check("short write", 24'h000000, st());
    xfer(64'h50, 8);
    check("volatile no latch", 24'h000000, st());
    xfer(64'h0180, 16);
    check("volatile write", 24'h000080, st());
    $display("test status finished");
    xfer(64'h0003_0012_fe00_0000, 56);
    check("read stream", {mem(24'h0012fe), mem(24'h0012ff), mem(24'h001300)}, rx[23:0]);
    xfer(64'h000b_00ab_1000_0000, 56);
    check("fast read", {8'h00, mem(24'h00ab10), mem(24'h00ab11)}, {8'h00, rx[15:0]});
    @(posedge clk);
    arrayBusy <= 1'b1;
    xfer(64'h03_0012_fe00, 40);
    check("read while array busy", 24'h000000, {16'h0000, rx[7:0]});
    check("address kept while busy", 24'h00ab13, memAddr_q);
    @(posedge clk);
    arrayBusy <= 1'b0;
    $display("test read finished");
    xfer(64'h06, 8);
    repeat (4) @(posedge clk);
    arrayOpDone <= 1'b1;
    swReset <= 1'b1;
    @(posedge clk);
    arrayOpDone <= 1'b0;
    swReset <= 1'b0;
    @(posedge clk);
    check("latch after array done", 24'h000080, st());
    $display("test array done finished");
    @(posedge clk);
    fourWire <= 1'b1;
    xfer(64'h06, 2);
    xfer(64'h50, 2);
    xfer(64'h0180be, 6);
    check("four-wire volatile write", 24'h000282, st());
    xfer(64'h05_0000, 6);
    check("four-wire status read", 24'h008282, {8'h00, rx[15:0]});
    xfer(64'hc010, 4);
    xfer(64'h0b00_ab10_0000_0000, 16);
    check("six dummy fast read", 24'h0000bb, {16'h0000, rx[7:0]});
    @(posedge clk);
    swReset <= 1'b1;
    @(posedge clk);
    swReset <= 1'b0;
    xfer(64'h000b_00ab_2000_0000, 14);
    check("default dummy fast read", 24'h00008b, {16'h0000, rx[7:0]});
    $display("test four-wire finished");
    finish_test();
  end
endmodule

// >>> sim/serial_flash_host.sv
// host controller model driving the serial link
`timescale 1ns/1ps
module serial_flash_host (
  output logic sclk,
  output logic csN,
  output logic [3:0] ioIn,
  input wire logic [3:0] lanes
);
  // link idles with clock low and chip select high
  initial
  begin
    sclk = 1'b0;
    csN = 1'b1;
    ioIn = 4'h0;
  end
  // one frame of n clocks, a bit or a nibble each; returned data lags one falling edge
  task automatic frame(input logic [63:0] tx, input int n, input logic quad,
                       output logic [63:0] rx);
    rx = '0;
    #3;
    csN = 1'b0;
    #80;
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk = 1'b0;
      rx = quad ? {rx[59:0], lanes} : {rx[62:0], lanes[1]};
      if (quad)
        ioIn = tx[4 * i +: 4];
      else
        ioIn[0] = tx[i];
      #80;
      sclk = 1'b1;
      #80;
    end
    sclk = 1'b0;
    rx = quad ? {rx[59:0], lanes} : {rx[62:0], lanes[1]};
    #80;
    csN = 1'b1;
    ioIn = ~ioIn; // released lanes show the inverse of the last value
    #100;
  endtask
endmodule
